//--- inc/dcse_if.sv
// link between the host bridge and the channel status device
`timescale 1ns/10ps
`default_nettype none
interface dcse_if;
	logic acc_req;
	logic acc_wr;
	logic [7:0] acc_addr;
	logic [7:0] acc_wdata;
	logic acc_ack;
	logic [7:0] acc_rdata;
	logic periph_control_line;
	// device end answers register accesses
	modport dev (
		input acc_req, acc_wr, acc_addr, acc_wdata, periph_control_line,
		output acc_ack, acc_rdata
	);
	// host end issues accesses and drives the control line
	modport host (
		output acc_req, acc_wr, acc_addr, acc_wdata, periph_control_line,
		input acc_ack, acc_rdata
	);
endinterface
`default_nettype wire

//--- inc/dcse_pkg.sv
// constants shared by both ends of the channel status and fault block
// Notes on behaviour
// - set op_done_flag whenever an operation ends
// - host clears op_done_flag before new operation
// - block_done_flag: count out, unchained, continue set
// - continuation with block_done_flag set: timing fault
// - device_end_flag set on device-ended transfer
// - fault sets error flag and records cause
// - clearing error flag clears cause to zero
// - running flag from start to end, write-proof
// - line_fall_flag set on falling control line
// - bit 0 shows live control line level
// - device sets flags, write-one clears, reset clears
// - host writes zero to reserved bit 2
// - cause register read-only, five-bit code
// - fixed codes for config, timing, aborts
// - address, count, bus codes carry source bits
// - interrupt request gated by enable and flags
// - fault vector while error flag set
package dcse_pkg;
	// register offsets seen over the device's own port
	localparam logic [7:0] DCSE_OFS_STATE = 8'h00;
	localparam logic [7:0] DCSE_OFS_CAUSE = 8'h01;
	// bit positions in channel_state_flags
	localparam int DCSE_B_OP_DONE = 7;
	localparam int DCSE_B_BLOCK_DONE = 6;
	localparam int DCSE_B_DEV_END = 5;
	localparam int DCSE_B_ERR = 4;
	localparam int DCSE_B_RUNNING = 3;
	localparam int DCSE_B_RSVD = 2;
	localparam int DCSE_B_LINE_FALL = 1;
	localparam int DCSE_B_LINE_LEVEL = 0;
	// fault codes held in channel_fault_cause
	localparam logic [4:0] DCSE_C_NONE = 5'h00;
	localparam logic [4:0] DCSE_C_CONFIG = 5'h01;
	localparam logic [4:0] DCSE_C_TIMING = 5'h02;
	localparam logic [4:0] DCSE_C_EXT_ABORT = 5'h10;
	localparam logic [4:0] DCSE_C_SW_ABORT = 5'h11;
	// class prefixes, low two bits name the source
	localparam logic [2:0] DCSE_CL_ADDR = 3'h1;
	localparam logic [2:0] DCSE_CL_BUS = 3'h2;
	localparam logic [2:0] DCSE_CL_COUNT = 3'h3;
	localparam logic [1:0] DCSE_SRC_MEM = 2'h1;
	localparam logic [1:0] DCSE_SRC_DEV = 2'h2;
	localparam logic [1:0] DCSE_SRC_BASE = 2'h3;
	// host-side avalon byte offsets
	localparam logic [3:0] DCSE_AV_STATE = 4'h0;
	localparam logic [3:0] DCSE_AV_CAUSE = 4'h4;
	localparam logic [3:0] DCSE_AV_LINE = 4'h8;
	localparam logic [7:0] DCSE_LINE_RST = 8'h01;
	typedef enum {DCSE_H_IDLE, DCSE_H_WAIT, DCSE_H_RESP} dcse_host_state_t;
endpackage

//--- sim/dcse_checker.sv
// link checks between the host bridge and the channel device
`timescale 1ns/10ps
`default_nettype none
module dcse_checker import dcse_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic acc_req_i,
	input wire logic acc_wr_i,
	input wire logic [7:0] acc_addr_i,
	input wire logic [7:0] acc_wdata_i,
	input wire logic acc_ack_i,
	input wire logic [7:0] acc_rdata_i,
	input wire logic periph_control_line_i
);
	// reads of the two device registers
	wire rd_st = acc_req_i && !acc_wr_i && acc_addr_i == DCSE_OFS_STATE;
	wire rd_ca = acc_req_i && !acc_wr_i && acc_addr_i == DCSE_OFS_CAUSE;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// one answer per request, exactly one cycle later
	ack_follows_req_a: assert property (acc_req_i |=> acc_ack_i) else $error("no answer");
	ack_single_a: assert property (acc_ack_i |-> $past(acc_req_i) && !$past(acc_ack_i))
		else $error("stray answer");
	// read data must not drift while nothing new is asked
	rdata_hold_a: assert property (acc_ack_i ##1 !acc_req_i |-> $stable(acc_rdata_i))
		else $error("read data moved");
	// reserved bit is never written as one and never read as one
	rsvd_write_a: assert property (acc_req_i && acc_wr_i && acc_addr_i == DCSE_OFS_STATE |->
		!acc_wdata_i[DCSE_B_RSVD]) else $error("reserved bit written");
	rsvd_read_a: assert property (rd_st |=> !acc_rdata_i[DCSE_B_RSVD])
		else $error("reserved bit set");
	cause_upper_a: assert property (rd_ca |=> acc_rdata_i[7:5] == 3'h0)
		else $error("cause upper bits set");
	cause_code_a: assert property (rd_ca |=> acc_rdata_i[4:0] <= 5'h11 &&
		!(acc_rdata_i[4:0] inside {5'h03, 5'h04, 5'h08, 5'h0C})) else $error("bad cause code");
	// level bit follows the line once the synchroniser has settled
	level_bit_a: assert property ($stable(periph_control_line_i)[*4] ##0 rd_st |=>
		acc_rdata_i[0] == $past(periph_control_line_i)) else $error("level bit wrong");
	fall_flag_a: assert property ($fell(periph_control_line_i) ##1
		(!periph_control_line_i && !acc_req_i)[*2] ##1 rd_st |=> acc_rdata_i[1])
		else $error("fall not flagged");
	line_reset_a: assert property ($fell(sys_rst_i) |-> periph_control_line_i)
		else $error("line not high after reset");
endmodule
`default_nettype wire

//--- sim/dma_channel_status_error_tb.sv
// self-checking bench for both ends of the channel status and fault block
`timescale 1ns/10ps
`default_nettype none
module dma_channel_status_error_tb import dcse_pkg::*; ();
	localparam logic [3:0] ST = DCSE_AV_STATE;
	localparam logic [3:0] CA = DCSE_AV_CAUSE;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [5:0] ev_v = 6'h00;
	logic chained_i = 1'b0;
	logic cont_opt_i = 1'b0;
	logic [4:0] fault_code_i = 5'h00;
	logic irq_enable_i = 1'b0;
	logic line_irq_mode_i = 1'b0;
	logic irq_o;
	logic running_o;
	logic [7:0] vector_o;
	logic [7:0] state_flags_o;
	int err_count = 0;
	int checks = 0;
	logic [4:0] codes [12] = '{5'h01, 5'h10, 5'h11, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B,
		5'h0D, 5'h0E, 5'h0F};
	dcse_if i_dcse_if ();
	dcse_host i_dcse_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .lnk(i_dcse_if.host));
	dcse_device i_dcse_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(i_dcse_if.dev),
		.start_i(ev_v[0]), .op_end_i(ev_v[1]), .count_out_i(ev_v[2]), .chained_i(chained_i),
		.cont_opt_i(cont_opt_i), .cont_try_i(ev_v[3]), .dev_end_i(ev_v[4]), .fault_i(ev_v[5]),
		.fault_code_i(fault_code_i), .irq_enable_i(irq_enable_i),
		.line_irq_mode_i(line_irq_mode_i), .normal_vector_reg_i(8'h3C),
		.fault_vector_reg_i(8'hC3), .irq_o(irq_o), .vector_o(vector_o), .running_o(running_o),
		.state_flags_o(state_flags_o));
	dcse_checker i_dcse_checker (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.acc_req_i(i_dcse_if.acc_req), .acc_wr_i(i_dcse_if.acc_wr),
		.acc_addr_i(i_dcse_if.acc_addr), .acc_wdata_i(i_dcse_if.acc_wdata),
		.acc_ack_i(i_dcse_if.acc_ack), .acc_rdata_i(i_dcse_if.acc_rdata),
		.periph_control_line_i(i_dcse_if.periph_control_line));
	// comparisons, each counted
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({7'h00, got}, {7'h00, exp});
	endtask
	task automatic chk_outs(input logic [7:0] f, input logic i);
		// values seen at the next edge are the settled ones, and later drives stay on edges
		@(posedge clk_i);
		chk_reg(state_flags_o, f);
		chk_bit(irq_o, i);
		chk_bit(running_o, f[3]);
	endtask
	// avalon accesses hold until waitrequest is seen low, the watchdog cuts a hang
	task automatic av_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		avs_read_i <= 1'b1;
		avs_address_i <= a;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		chk_reg(avs_readdata_o[7:0], exp);
	endtask
	task automatic av_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		avs_write_i <= 1'b1;
		avs_address_i <= a;
		avs_writedata_i <= {24'h000000, d};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
	endtask
	// one-cycle event pulse, returns once irq and the flag copy have settled
	task automatic ev(input int k);
		@(posedge clk_i);
		ev_v[k] <= 1'b1;
		@(posedge clk_i);
		ev_v <= 6'h00;
		@(posedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// clock and watchdog
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		av_rd(ST, 8'h01);
		av_rd(CA, 8'h00);
		av_rd(4'hC, 8'h00);
		chk_outs(8'h01, 1'b0);
		$display("test reset done");
		ev(0);
		chk_outs(8'h09, 1'b0);
		av_wr(ST, 8'hFF);
		av_rd(ST, 8'h09);
		irq_enable_i <= 1'b1;
		ev(1);
		chk_outs(8'h81, 1'b1);
		chk_reg(vector_o, 8'h3C);
		av_wr(ST, 8'h80);
		chk_outs(8'h01, 1'b0);
		$display("test run done");
		cont_opt_i <= 1'b1;
		chained_i <= 1'b1;
		ev(2);
		ev(3);
		chk_outs(8'h01, 1'b0);
		chained_i <= 1'b0;
		ev(2);
		chk_outs(8'h41, 1'b1);
		ev(3);
		chk_outs(8'h51, 1'b1);
		chk_reg(vector_o, 8'hC3);
		av_wr(CA, 8'hFF);
		av_rd(CA, 8'h02);
		av_wr(ST, 8'h50);
		av_rd(CA, 8'h00);
		chk_outs(8'h01, 1'b0);
		$display("test block done");
		for (int i = 0; i < 12; i++) begin
			fault_code_i <= codes[i];
			ev(5);
			av_rd(CA, {3'h0, codes[i]});
			av_rd(ST, 8'h11);
			av_wr(ST, 8'h10);
			av_rd(CA, 8'h00);
		end
		ev(4);
		chk_outs(8'h21, 1'b0);
		av_wr(ST, 8'h20);
		av_rd(ST, 8'h01);
		$display("test codes done");
		av_wr(DCSE_AV_LINE, 8'h00);
		av_rd(ST, 8'h02);
		chk_outs(8'h02, 1'b0);
		line_irq_mode_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_outs(8'h02, 1'b1);
		av_wr(ST, 8'h02);
		av_rd(ST, 8'h00);
		av_wr(DCSE_AV_LINE, 8'h01);
		av_rd(ST, 8'h01);
		$display("test line done");
		fork
			av_wr(ST, 8'h80);
			begin
				repeat (2) @(posedge clk_i);
				ev_v[1] <= 1'b1;
				@(posedge clk_i);
				ev_v <= 6'h00;
			end
		join
		av_rd(ST, 8'h81);
		avs_byteenable_i <= 4'h0;
		av_wr(ST, 8'h80);
		av_rd(ST, 8'h81);
		avs_byteenable_i <= 4'hF;
		$display("test race done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

//--- src/dcse_device.sv
// channel status flags, fault cause and interrupt request of one channel
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dcse_device
	import dcse_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	dcse_if.dev lnk,
	input wire logic start_i,
	input wire logic op_end_i,
	input wire logic count_out_i,
	input wire logic chained_i,
	input wire logic cont_opt_i,
	input wire logic cont_try_i,
	input wire logic dev_end_i,
	input wire logic fault_i,
	input wire logic [4:0] fault_code_i,
	input wire logic irq_enable_i,
	input wire logic line_irq_mode_i,
	input wire logic [7:0] normal_vector_reg_i,
	input wire logic [7:0] fault_vector_reg_i,
	output logic irq_o,
	output logic [7:0] vector_o,
	output logic running_o,
	output logic [7:0] state_flags_o
);
	// synchroniser pair and the edge history behind it
	logic line_s1_reg;
	logic line_s2_reg;
	logic line_d_reg;
	// status flags and the fault cause with their next values
	logic op_done_flag_reg, op_done_flag_next;
	logic block_done_flag_reg, block_done_flag_next;
	logic device_end_flag_reg, device_end_flag_next;
	logic err_flag_reg, err_flag_next;
	logic channel_running_flag_reg, channel_running_flag_next;
	logic line_fall_flag_reg, line_fall_flag_next;
	logic [4:0] cause_reg, cause_next;
	// register port answer and the output flops
	logic ack_reg, ack_next;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic [7:0] vector_reg, vector_next;
	logic [7:0] flags_out_reg, flags_out_next;
	// combinational helpers, never seen outside
	logic [7:0] clr;
	logic timing_fault;
	logic any_fault;
	logic [4:0] new_code;
	logic line_fall;
	logic [7:0] state_word;

	// control line comes from the far party: two flops before any use
	// reset high matches the idle line, so leaving reset shows no false fall
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			line_s1_reg <= 1'b1;
			line_s2_reg <= 1'b1;
			line_d_reg <= 1'b1;
		end else begin
			line_s1_reg <= lnk.periph_control_line;
			line_s2_reg <= line_s1_reg;
			line_d_reg <= line_s2_reg;
		end
	end

	// falling edge seen on the synchronised copy only
	assign line_fall = line_d_reg && !line_s2_reg;

	// write-one clear mask, live for one cycle per write to the state word
	assign clr = (lnk.acc_req && lnk.acc_wr && lnk.acc_addr == DCSE_OFS_STATE)
		? lnk.acc_wdata : 8'h00;

	// a continuation while a block is still flagged is a timing fault
	assign timing_fault = cont_try_i && block_done_flag_reg;
	assign any_fault = fault_i || timing_fault;
	// external cause takes priority when both strike together
	// class and source bits come from the sequencer and pass through unchanged
	assign new_code = fault_i ? fault_code_i : DCSE_C_TIMING;

	// flag next values: each set term is or-ed after the write clear so the set wins, but op end beats start for running
	always_comb begin
		op_done_flag_next = op_done_flag_reg && !clr[DCSE_B_OP_DONE];
		if (op_end_i) begin
			op_done_flag_next = 1'b1;
		end
		// block done needs all three conditions in one cycle
		block_done_flag_next = block_done_flag_reg && !clr[DCSE_B_BLOCK_DONE];
		if (count_out_i && !chained_i && cont_opt_i) begin
			block_done_flag_next = 1'b1;
		end
		device_end_flag_next = device_end_flag_reg && !clr[DCSE_B_DEV_END];
		if (dev_end_i) begin
			device_end_flag_next = 1'b1;
		end
		line_fall_flag_next = line_fall_flag_reg && !clr[DCSE_B_LINE_FALL];
		if (line_fall) begin
			line_fall_flag_next = 1'b1;
		end
		// running ignores the write mask entirely
		channel_running_flag_next = channel_running_flag_reg;
		if (op_end_i) begin
			channel_running_flag_next = 1'b0;
		end else if (start_i) begin
			channel_running_flag_next = 1'b1;
		end
	end

	// error flag and cause move together; a first cause is kept until cleared
	// a clear and a fault together leave the flag set with the new code
	always_comb begin
		err_flag_next = err_flag_reg;
		cause_next = cause_reg;
		if (clr[DCSE_B_ERR]) begin
			err_flag_next = 1'b0;
			cause_next = DCSE_C_NONE;
		end
		if (any_fault && !(err_flag_reg && !clr[DCSE_B_ERR])) begin
			err_flag_next = 1'b1;
			cause_next = new_code;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_done_flag_reg <= 1'b0;
			block_done_flag_reg <= 1'b0;
			device_end_flag_reg <= 1'b0;
			err_flag_reg <= 1'b0;
			channel_running_flag_reg <= 1'b0;
			line_fall_flag_reg <= 1'b0;
			cause_reg <= DCSE_C_NONE;
		end else begin
			op_done_flag_reg <= op_done_flag_next;
			block_done_flag_reg <= block_done_flag_next;
			device_end_flag_reg <= device_end_flag_next;
			err_flag_reg <= err_flag_next;
			channel_running_flag_reg <= channel_running_flag_next;
			line_fall_flag_reg <= line_fall_flag_next;
			cause_reg <= cause_next;
		end
	end

	// assembled state word; bit 2 always reads zero, bit 0 is the live line
	always_comb begin
		state_word = 8'h00;
		state_word[DCSE_B_OP_DONE] = op_done_flag_reg;
		state_word[DCSE_B_BLOCK_DONE] = block_done_flag_reg;
		state_word[DCSE_B_DEV_END] = device_end_flag_reg;
		state_word[DCSE_B_ERR] = err_flag_reg;
		state_word[DCSE_B_RUNNING] = channel_running_flag_reg;
		state_word[DCSE_B_RSVD] = 1'b0; // reserved position never reads one
		state_word[DCSE_B_LINE_FALL] = line_fall_flag_reg;
		state_word[DCSE_B_LINE_LEVEL] = line_s2_reg;
	end

	// register port: one-cycle ack a cycle after each request
	always_comb begin
		ack_next = lnk.acc_req;
		rdata_next = rdata_reg;
		if (lnk.acc_req) begin
			case (lnk.acc_addr)
				DCSE_OFS_STATE: begin
					rdata_next = state_word;
				end
				DCSE_OFS_CAUSE: begin
					// writes here change nothing: the cause word is read-only
					rdata_next = {3'h0, cause_reg};
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// interrupt request and vector choice, held in flops for clean outputs
	// one cycle of lag is traded for glitch-free request and vector
	always_comb begin
		irq_next = irq_enable_i && (op_done_flag_reg || block_done_flag_reg
			|| (line_fall_flag_reg && line_irq_mode_i));
		vector_next = err_flag_reg ? fault_vector_reg_i : normal_vector_reg_i;
		flags_out_next = state_word;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
			vector_reg <= 8'h00;
			flags_out_reg <= 8'h00;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			vector_reg <= vector_next;
			flags_out_reg <= flags_out_next;
		end
	end

	// every output below is a flop, so nothing combinational leaves the block
	assign lnk.acc_ack = ack_reg;
	assign lnk.acc_rdata = rdata_reg;
	assign irq_o = irq_reg;
	assign vector_o = vector_reg;
	assign running_o = channel_running_flag_reg;
	assign state_flags_o = flags_out_reg;
endmodule
`default_nettype wire

//--- src/dcse_host.sv
// host bridge: avalon slave forwarding to the device and driving the line
`timescale 1ns/10ps
`default_nettype none
module dcse_host
	import dcse_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	dcse_if.host lnk
);
	dcse_host_state_t state_reg, state_next;
	logic req_reg, req_next;
	logic wr_reg, wr_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [7:0] line_reg, line_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wait_reg, wait_next;
	logic fwd;
	logic wr_ok;

	// only the state and cause words go across; bit 2 is forced to zero on writes
	assign fwd = (avs_address_i == DCSE_AV_STATE) || (avs_address_i == DCSE_AV_CAUSE);
	assign wr_ok = avs_write_i && avs_byteenable_i[0];

	// waitrequest rests high and drops for exactly the completing cycle
	always_comb begin
		state_next = state_reg;
		req_next = 1'b0;
		wr_next = wr_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		line_next = line_reg;
		rdata_next = rdata_reg;
		wait_next = 1'b1;
		case (state_reg)
			DCSE_H_IDLE: begin
				if ((avs_read_i || avs_write_i) && fwd && (avs_read_i || wr_ok)) begin
					req_next = 1'b1;
					wr_next = avs_write_i;
					addr_next = (avs_address_i == DCSE_AV_STATE) ? DCSE_OFS_STATE
						: DCSE_OFS_CAUSE;
					wdata_next = avs_writedata_i[7:0];
					wdata_next[DCSE_B_RSVD] = 1'b0;
					state_next = DCSE_H_WAIT;
				end else if (avs_read_i || avs_write_i) begin
					// local word or masked write: complete without the device
					if (wr_ok && avs_address_i == DCSE_AV_LINE) begin
						line_next = avs_writedata_i[7:0];
					end
					rdata_next = (avs_address_i == DCSE_AV_LINE) ? {24'h000000, line_reg}
						: 32'h00000000;
					wait_next = 1'b0;
					state_next = DCSE_H_RESP;
				end
			end
			DCSE_H_WAIT: begin
				if (lnk.acc_ack) begin
					rdata_next = {24'h000000, lnk.acc_rdata};
					wait_next = 1'b0;
					state_next = DCSE_H_RESP;
				end
			end
			DCSE_H_RESP: begin
				state_next = DCSE_H_IDLE;
			end
			default: begin
				state_next = DCSE_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= DCSE_H_IDLE;
			req_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= DCSE_OFS_STATE;
			wdata_reg <= 8'h00;
			line_reg <= DCSE_LINE_RST;
			rdata_reg <= 32'h00000000;
			wait_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			wr_reg <= wr_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			line_reg <= line_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
		end
	end

	assign lnk.acc_req = req_reg;
	assign lnk.acc_wr = wr_reg;
	assign lnk.acc_addr = addr_reg;
	assign lnk.acc_wdata = wdata_reg;
	assign lnk.periph_control_line = line_reg[0];
	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
endmodule
`default_nettype wire
